/* File: clbcs_bus_cycle.sv */
// What this block does
// - minimum mode: direction output high to transmit, low to receive
// - direction timed like memory/io select, equal to middle status bit
// - memory/io select valid from preceding fourth state to final fourth state
// - during hold acknowledge, direction and transceiver enable float high
// - transceiver enable low for memory, io and interrupt acknowledge cycles only
// - reads and interrupt acknowledge: enable from mid second to mid fourth state
// - writes: enable from start of second to mid fourth state
// - grant acknowledge rises mid fourth state or mid idle state
// - bus and control outputs float together with the grant acknowledge
// - request low drops the grant; bus driven again only for a new cycle
// - maximum mode: status active in preceding fourth, first and second states
// - status returns passive in third state, or wait state when ready high
// - status leaving passive starts a cycle, returning to passive ends it
// - status outputs float high during a grant sequence
// - codes 000 irq ack, 001 io read, 010 io write, 011 halt
`timescale 1ns/1ps
module clbcs_bus_cycle
  import clbcs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       holdReq,
  input  wire logic       readyIn,
  input  wire logic       minMaxSelect,
  input  wire logic       reqValid,
  input  wire logic [2:0] reqCode,
  output logic            reqReady,
  output logic            cycDone,
  output logic            busFloat,
  output logic            busGrantAck,
  output logic            memIoSelect,
  output logic            memIoOe,
  output logic            xmitRecvDir,
  output logic            xmitRecvOe,
  output logic            xcvrEnableN,
  output logic            xcvrEnableOe,
  output logic [2:0]      cycleStatus,
  output logic            cycleStatusOe
);

  typedef struct packed {
    clbcs_tstate_e tst;
    logic          half;
    logic          lead;
    logic [2:0]    code;
    logic [2:0]    status;
    logic          xcvrEnN;
    logic          float;
    logic          grant;
    logic          done;
    logic [2:0]    strapCnt;
    logic          strapDone;
    logic          modeMax;
  } clbcs_state_s;

  function automatic logic isXfer(input logic [2:0] code);
    isXfer = (code != CODE_HALT) && (code != CODE_PASSIVE);
  endfunction

  function automatic logic isWrite(input logic [2:0] code);
    isWrite = (code == CODE_IO_WR) || (code == CODE_MEM_WR);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic [1:0] rstPipe_ff;
  logic       rstSync_n;
  logic [2:0] pinSync;
  logic       holdSync;
  logic       readySync;
  logic       strapSync;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe_ff[1];

  // hold request synchronised here too, costing latency the requester must tolerate
  clbcs_pin_sync #(
    .WIDTH (SYNC_STAGES)
  ) u_pin_sync (
    .clock     (clock),
    .rstSync_n (rstSync_n),
    .pinIn     ({holdReq, readyIn, minMaxSelect}),
    .pinAgreed (pinSync)
  );

  assign holdSync  = pinSync[2];
  assign readySync = pinSync[1];
  assign strapSync = pinSync[0];

  //////////////////////////////////////////////////////////////////////////////
  // bus state sequencer

  clbcs_state_s state_ff;
  clbcs_state_s nxt_state;
  logic         canStart;

  // a new cycle may begin at the end of an idle state or mid final fourth state
  assign canStart = state_ff.strapDone && !holdSync
                 && (((state_ff.tst == ST_IDLE) && state_ff.half)
                  || ((state_ff.tst == ST_FOURTH) && !state_ff.half && !state_ff.lead));

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.done = 1'b0;
    // strap is caught once after release so a stray glitch later cannot flip modes
    if (!state_ff.strapDone) begin
      nxt_state.strapCnt = state_ff.strapCnt + 3'h1;
      if (state_ff.strapCnt == STRAP_SETTLE) begin
        nxt_state.strapDone = 1'b1;
        nxt_state.modeMax   = !strapSync;
      end
    end
    unique case (state_ff.tst)
      ST_IDLE: begin
        if (!state_ff.half) begin
          if (holdSync) begin
            nxt_state.tst   = ST_HOLD;
            nxt_state.grant = 1'b1;
            nxt_state.float = 1'b1;
          end else begin
            nxt_state.half = 1'b1;
          end
        end else begin
          nxt_state.half = 1'b0;
          if (canStart && reqValid) begin
            nxt_state.tst    = ST_FOURTH;
            nxt_state.lead   = 1'b1;
            nxt_state.code   = reqCode;
            nxt_state.status = reqCode;
            nxt_state.float  = 1'b0;
          end
        end
      end
      ST_FOURTH: begin
        if (!state_ff.half) begin
          nxt_state.half = 1'b1;
          if (!state_ff.lead) begin
            nxt_state.xcvrEnN = 1'b1;
            nxt_state.done    = 1'b1;
            if (holdSync) begin
              nxt_state.tst   = ST_HOLD;
              nxt_state.half  = 1'b0;
              nxt_state.grant = 1'b1;
              nxt_state.float = 1'b1;
            end else if (reqValid) begin
              nxt_state.lead   = 1'b1;
              nxt_state.code   = reqCode;
              nxt_state.status = reqCode;
            end
          end
        end else begin
          nxt_state.half = 1'b0;
          if (state_ff.lead) begin
            nxt_state.tst  = ST_FIRST;
            nxt_state.lead = 1'b0;
          end else begin
            nxt_state.tst = ST_IDLE;
          end
        end
      end
      ST_FIRST: begin
        nxt_state.half = !state_ff.half;
        if (state_ff.half) begin
          nxt_state.tst = ST_SECOND;
          if (isWrite(state_ff.code)) begin
            nxt_state.xcvrEnN = 1'b0;
          end
        end
      end
      ST_SECOND: begin
        nxt_state.half = !state_ff.half;
        if (!state_ff.half) begin
          if (isXfer(state_ff.code)) begin
            nxt_state.xcvrEnN = 1'b0;
          end
        end else begin
          nxt_state.tst = ST_THIRD;
          if (readySync) begin
            nxt_state.status = CODE_PASSIVE;
          end
        end
      end
      ST_THIRD, ST_WAIT: begin
        nxt_state.half = !state_ff.half;
        if (readySync) begin
          nxt_state.status = CODE_PASSIVE;
        end
        if (state_ff.half) begin
          nxt_state.tst = readySync ? ST_FOURTH : ST_WAIT;
        end
      end
      ST_HOLD: begin
        if (!holdSync) begin
          nxt_state.tst   = ST_IDLE;
          nxt_state.half  = 1'b0;
          nxt_state.grant = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_ff           <= '0;
      state_ff.tst       <= ST_IDLE;
      state_ff.code      <= RST_CODE;
      state_ff.status    <= RST_CODE;
      state_ff.xcvrEnN   <= RST_XCVR_EN_N;
      state_ff.float     <= RST_FLOAT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drive; a floated pin resolves high outside

  logic minDrive;
  logic maxDrive;

  assign minDrive      = state_ff.strapDone && !state_ff.modeMax && !state_ff.float;
  assign maxDrive      = state_ff.strapDone && state_ff.modeMax && !state_ff.float;
  assign reqReady      = canStart;
  assign cycDone       = state_ff.done;
  assign busFloat      = state_ff.float;
  assign busGrantAck   = state_ff.grant;
  assign memIoSelect   = state_ff.code[POS_MEM_IO];
  assign memIoOe       = minDrive;
  assign xmitRecvDir   = state_ff.code[POS_DIR];
  assign xmitRecvOe    = minDrive;
  assign xcvrEnableN   = state_ff.xcvrEnN;
  assign xcvrEnableOe  = minDrive;
  assign cycleStatus   = state_ff.status;
  assign cycleStatusOe = maxDrive;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync_n);

  sequence sLeadEnd;
    (state_ff.tst == ST_FOURTH) && state_ff.lead && state_ff.half;
  endsequence

  sequence sEarlyStates;
    (state_ff.tst == ST_FIRST) && !state_ff.half ##2 (state_ff.tst == ST_SECOND);
  endsequence

  a_grant_mid_state: assert property ($rose(busGrantAck) |->
    (($past(state_ff.tst) == ST_IDLE) || ($past(state_ff.tst) == ST_FOURTH)) && !$past(state_ff.half))
    else $error("grant raised outside mid idle or fourth state");

  a_grant_floats: assert property (busGrantAck |-> busFloat && !xcvrEnableOe
    && !xmitRecvOe && !cycleStatusOe && !memIoOe)
    else $error("outputs driven while grant acknowledged");

  a_grant_drop: assert property (busGrantAck && !holdSync |=> !busGrantAck ##1 !xcvrEnableOe)
    else $error("grant not dropped or bus driven without a cycle");

  a_status_early: assert property (sLeadEnd |=> sEarlyStates ##0 (cycleStatus != CODE_PASSIVE))
    else $error("status not active through first and second states");

  a_status_passive: assert property (((state_ff.tst == ST_THIRD) && $past(readySync))
    || ((state_ff.tst == ST_FOURTH) && !state_ff.lead) |-> cycleStatus == CODE_PASSIVE)
    else $error("status not passive after third state with ready");

  a_write_en_start: assert property ((state_ff.tst == ST_SECOND) && !state_ff.half
    && isWrite(state_ff.code) |-> !xcvrEnableN)
    else $error("write enable missing at start of second state");

  a_read_en_mid: assert property ((state_ff.tst == ST_SECOND) && !state_ff.half
    && !isWrite(state_ff.code) |-> xcvrEnableN ##1 (xcvrEnableN == !isXfer(state_ff.code)))
    else $error("read enable not at middle of second state");

  a_en_end_mid: assert property ((state_ff.tst == ST_FOURTH) && !state_ff.lead
    && state_ff.half |-> xcvrEnableN)
    else $error("enable still active after middle of fourth state");

  a_en_kind: assert property (!xcvrEnableN |-> isXfer(state_ff.code))
    else $error("enable active for halt or passive code");

  a_memio_stable: assert property ((state_ff.tst inside {ST_FIRST, ST_SECOND, ST_THIRD, ST_WAIT})
    |-> $stable(memIoSelect) && (xmitRecvDir == isWrite(state_ff.code)
    || state_ff.code == CODE_HALT))
    else $error("select or direction changed inside a cycle");

endmodule

/* File: clbcs_pkg.sv */
package clbcs_pkg;

  // bus states, each but hold split into two clock halves so mid-state edges exist
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND,
    ST_THIRD,
    ST_WAIT,
    ST_FOURTH,
    ST_HOLD
  } clbcs_tstate_e;

  // cycle codes, most significant bit first
  localparam logic [2:0] CODE_IRQ_ACK  = 3'h0;
  localparam logic [2:0] CODE_IO_RD    = 3'h1;
  localparam logic [2:0] CODE_IO_WR    = 3'h2;
  localparam logic [2:0] CODE_HALT     = 3'h3;
  localparam logic [2:0] CODE_FETCH    = 3'h4;
  localparam logic [2:0] CODE_MEM_RD   = 3'h5;
  localparam logic [2:0] CODE_MEM_WR   = 3'h6;
  localparam logic [2:0] CODE_PASSIVE  = 3'h7;

  // field positions inside a cycle code
  localparam int unsigned POS_MEM_IO   = 2;
  localparam int unsigned POS_DIR      = 1;

  // reset values
  localparam logic [2:0] RST_CODE      = CODE_PASSIVE;
  localparam logic       RST_XCVR_EN_N = 1'b1;
  localparam logic       RST_FLOAT     = 1'b0;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned HALVES_PER_TST  = 2;
  localparam int unsigned SYNC_STAGES     = 3;
  // strap synchroniser only agrees after four edges, so wait past that
  localparam logic [2:0]  STRAP_SETTLE    = 3'h5;

endpackage

/* File: clbcs_pin_sync.sv */
`timescale 1ns/1ps
module clbcs_pin_sync
  import clbcs_pkg::*;
#(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             rstSync_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinAgreed
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agreed;
  } clbcs_sync_s;

  clbcs_sync_s state_ff;
  clbcs_sync_s nxt_state;

  // stage1 feeds stage2 only; a bit moves once stage2 and stage3 agree
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.stage1 = pinIn;
    nxt_state.stage2 = state_ff.stage1;
    nxt_state.stage3 = state_ff.stage2;
    nxt_state.agreed = (state_ff.stage2 & state_ff.stage3)
                     | (state_ff.agreed & (state_ff.stage2 | state_ff.stage3));
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pinAgreed = state_ff.agreed;

endmodule

/* File: clbcs_far_side.sv */
`timescale 1ns/1ps
module clbcs_far_side
  import clbcs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       holdWant,
  input  wire logic       readyWant,
  input  wire logic       memIoSelect,
  input  wire logic       memIoOe,
  input  wire logic       xmitRecvDir,
  input  wire logic       xmitRecvOe,
  input  wire logic       xcvrEnableN,
  input  wire logic       xcvrEnableOe,
  input  wire logic [2:0] cycleStatus,
  input  wire logic       cycleStatusOe,
  output logic            holdReq,
  output logic            readyIn,
  output logic            memIoPin,
  output logic            dirPin,
  output logic            xcvrEnPin,
  output logic [2:0]      statusPin,
  output int              cycStarts
);
  logic wasPassive;
  // board pull-ups: a released pin reads high
  assign memIoPin  = memIoOe ? memIoSelect : 1'b1;
  assign dirPin    = xmitRecvOe ? xmitRecvDir : 1'b1;
  assign xcvrEnPin = xcvrEnableOe ? xcvrEnableN : 1'b1;
  assign statusPin = cycleStatusOe ? cycleStatus : CODE_PASSIVE;
  initial begin
    holdReq    = 1'b0;
    readyIn    = 1'b1;
    cycStarts  = 0;
    wasPassive = 1'b1;
  end
  // moved half a clock before sampling, so setup is always met
  always @(negedge clock) begin
    holdReq <= holdWant;
    readyIn <= readyWant;
  end
  // bus controller view: leaving passive opens a cycle
  always @(posedge clock) begin
    if (wasPassive && statusPin != CODE_PASSIVE) cycStarts <= cycStarts + 1;
    wasPassive <= (statusPin == CODE_PASSIVE);
  end
endmodule

/* File: clbcs_bus_cycle_tb.sv */
`timescale 1ns/1ps
module clbcs_bus_cycle_tb;
  import clbcs_pkg::*;
  logic       clock, rst_n, minMaxSelect, reqValid, holdWant, readyWant;
  logic [2:0] reqCode, statusPin, cycleStatus;
  logic       holdReq, readyIn, reqReady, cycDone, busFloat, busGrantAck;
  logic       memIoSelect, memIoOe, xmitRecvDir, xmitRecvOe, xcvrEnableN;
  logic       xcvrEnableOe, cycleStatusOe, memIoPin, dirPin, xcvrEnPin;
  int         cycStarts, error_cnt, num_checks, cycles, startBase, c;

  clbcs_bus_cycle dut (.clock(clock), .rst_n(rst_n), .holdReq(holdReq), .readyIn(readyIn),
    .minMaxSelect(minMaxSelect), .reqValid(reqValid), .reqCode(reqCode), .reqReady(reqReady),
    .cycDone(cycDone), .busFloat(busFloat), .busGrantAck(busGrantAck),
    .memIoSelect(memIoSelect), .memIoOe(memIoOe), .xmitRecvDir(xmitRecvDir),
    .xmitRecvOe(xmitRecvOe), .xcvrEnableN(xcvrEnableN), .xcvrEnableOe(xcvrEnableOe),
    .cycleStatus(cycleStatus), .cycleStatusOe(cycleStatusOe));
  clbcs_far_side far (.clock(clock), .holdWant(holdWant), .readyWant(readyWant),
    .memIoSelect(memIoSelect), .memIoOe(memIoOe), .xmitRecvDir(xmitRecvDir),
    .xmitRecvOe(xmitRecvOe), .xcvrEnableN(xcvrEnableN), .xcvrEnableOe(xcvrEnableOe),
    .cycleStatus(cycleStatus), .cycleStatusOe(cycleStatusOe), .holdReq(holdReq),
    .readyIn(readyIn), .memIoPin(memIoPin), .dirPin(dirPin), .xcvrEnPin(xcvrEnPin),
    .statusPin(statusPin), .cycStarts(cycStarts));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check1(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic check3(input string what, input logic [2:0] e, input logic [2:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic doReset(input logic strap);
    rst_n        = 1'b0;
    minMaxSelect = strap;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    repeat (12) @(negedge clock);
  endtask
  // request held until taken; returns at the falling edge half a clock after the taking edge
  task automatic issue(input logic [2:0] code, input logic keep);
    int n;
    n        = 0;
    reqCode  = code;
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    check1("request taken", 1'b1, reqReady);
    @(negedge clock);
    reqValid = keep;
  endtask
  task automatic runCycle(input logic [2:0] code, input logic mx);
    logic rd, wr, enExp;
    rd = code inside {CODE_IRQ_ACK, CODE_IO_RD, CODE_FETCH, CODE_MEM_RD};
    wr = code inside {CODE_IO_WR, CODE_MEM_WR};
    issue(code, 1'b0);
    for (int k = 1; k <= 10; k++) begin
      enExp = rd ? !(k >= 6 && k <= 9) : wr ? !(k >= 5 && k <= 9) : 1'b1;
      if (mx) check3("status", (k <= 6) ? code : CODE_PASSIVE, statusPin);
      else begin
        check1("xcvr enable", enExp, xcvrEnPin);
        if (k <= 9) check1("mem io", code[POS_MEM_IO], memIoPin);
        if (k <= 9) check1("direction", code[POS_DIR], dirPin);
      end
      check1("done", k == 10, cycDone);
      @(negedge clock);
    end
  endtask
  task automatic holdSeq(input logic mx, input logic mid);
    int n;
    if (mid) issue(CODE_IO_RD, 1'b0);
    holdWant = 1'b1;
    for (n = 1; mid && n < 10; n++) begin
      check1("grant in cycle", 1'b0, busGrantAck);
      @(negedge clock);
    end
    n = 0;
    while (busGrantAck !== 1'b1 && n < 12) begin
      @(negedge clock);
      n++;
    end
    check1("grant", 1'b1, busGrantAck);
    check1("float", 1'b1, busFloat);
    // idle pins read high anyway, so the drive enables are what prove the float
    if (mx) begin
      check3("status float", CODE_PASSIVE, statusPin);
      check1("status oe", 1'b0, cycleStatusOe);
    end else begin
      check1("dir float", 1'b1, dirPin);
      check1("enable float", 1'b1, xcvrEnPin);
      check1("enable oe", 1'b0, xcvrEnableOe);
    end
    holdWant = 1'b0;
    n        = 0;
    while (busGrantAck !== 1'b0 && n < 12) begin
      @(negedge clock);
      n++;
    end
    check1("grant drop", 1'b0, busGrantAck);
    check1("float kept", 1'b1, busFloat);
    runCycle(CODE_MEM_RD, mx);
  endtask
  // ready low holds status active; cycle ends only after ready returns
  task automatic waitCycle;
    int n;
    readyWant = 1'b0;
    issue(CODE_MEM_RD, 1'b0);
    repeat (7) @(negedge clock);
    check3("status in wait", CODE_MEM_RD, statusPin);
    check1("done early", 1'b0, cycDone);
    readyWant = 1'b1;
    n         = 0;
    while (cycDone !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check1("done after wait", 1'b1, cycDone);
    check3("status passive", CODE_PASSIVE, statusPin);
    @(negedge clock);
  endtask
  task automatic backToBack;
    int n;
    issue(CODE_FETCH, 1'b1);
    reqCode = CODE_MEM_WR;
    repeat (9) @(negedge clock);
    check1("first done", 1'b1, cycDone);
    check3("next status", CODE_MEM_WR, statusPin);
    reqValid = 1'b0;
    n        = 0;
    do begin
      @(negedge clock);
      n++;
    end while (cycDone !== 1'b1 && n < 12);
    check1("second done", 1'b1, cycDone);
    check3("status end", CODE_PASSIVE, statusPin);
    @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ceiling well above the few hundred clocks the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    {rst_n, reqValid, holdWant, reqCode} = '0;
    {minMaxSelect, readyWant}            = 2'h3;
    {error_cnt, num_checks, cycles}      = '0;
    @(negedge clock);
    doReset(1'b1);
    for (c = 0; c < 7; c++) runCycle(c[2:0], 1'b0);
    holdSeq(1'b0, 1'b0);
    holdSeq(1'b0, 1'b1);
    doReset(1'b0);
    startBase = cycStarts;
    for (c = 0; c < 7; c++) runCycle(c[2:0], 1'b1);
    check1("cycle starts", 1'b1, cycStarts - startBase == 7);
    waitCycle();
    holdSeq(1'b1, 1'b0);
    backToBack();
    conclude();
  end
endmodule
